// ==== hdl/wlc_regs.svh ====
// Register offsets, field positions, reset values and rate constants
`ifndef WLC_REGS_SVH
`define WLC_REGS_SVH
`define WLC_CTRL_OFS 4'h0
`define WLC_STATUS_OFS 4'h4
`define WLC_LINK_OFS 4'h8
`define WLC_GPIO_OFS 4'hC
`define WLC_CTRL_READY_BIT 0
`define WLC_MODE_ON 3'h0
`define WLC_MODE_PS1 3'h1
`define WLC_MODE_PS2 3'h2
`define WLC_MODE_PS5 3'h5
`define WLC_MODE_RST 3'h5
`define WLC_BAUD_RST 3'h4
`define WLC_BAUD_MAX 3'h6
`define WLC_PAR_NONE 2'h0
`define WLC_PAR_BAD 2'h3
`define WLC_CHAN_RST 4'h1
`define WLC_REGION_RST 2'h0
`define WLC_REGION_BAD 2'h3
`define WLC_CHMAX_EU 4'hB
`define WLC_CHMAX_US 4'hD
`define WLC_CHMAX_JP 4'hE
`define WLC_KEY64_DIGITS 8'h0A
`define WLC_KEY128_DIGITS 8'h1A
`define WLC_UA_LEN8 4'h8
`define WLC_UA_BAUD 2:0
`define WLC_UA_PAR 5:4
`define WLC_UA_STOP 8
`define WLC_UA_LEN 15:12
`define WLC_KEY_DIGITS 7:0
`define WLC_CHAN_FLD 3:0
`define WLC_MODE_FLD 2:0
`define WLC_REGION_FLD 1:0
`define WLC_FLAG_BIT 0
`define WLC_CLK_HZ 125000000
`define WLC_BAUD_9600 9600
`define WLC_BAUD_19200 19200
`define WLC_BAUD_38400 38400
`define WLC_BAUD_57600 57600
`define WLC_BAUD_115200 115200
`define WLC_BAUD_230400 230400
`define WLC_BAUD_921600 921600
`endif

// ==== hdl/wlc_pkg.sv ====
// Types shared by the command interpreter and its users
package wlc_pkg;
  typedef enum logic [4:0] {
    uart_config_cmd = 5'h00, security_cmd = 5'h01, key_cmd = 5'h02,
    auth_cmd = 5'h03, search_cmd = 5'h04, attach_cmd = 5'h05,
    detach_cmd = 5'h06, network_type_cmd = 5'h07, channel_cmd = 5'h08,
    hw_addr_cmd = 5'h09, low_power_cmd = 5'h0A,
    signal_level_query = 5'h0B, region_query = 5'h0C,
    region_set_cmd = 5'h0D, adc_setup_cmd = 5'h0E,
    adc_sample_cmd = 5'h0F, pin_dir_out_cmd = 5'h10,
    pin_dir_in_cmd = 5'h11, pin_drive_high_cmd = 5'h12,
    pin_drive_low_cmd = 5'h13, pin_sense_cmd = 5'h14,
    version_query = 5'h15
  } wlc_op_e;
  typedef enum logic [1:0] {RSP_OK = 2'h0, RSP_REJECT = 2'h1} wlc_status_e;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RESP = 2'b10} wlc_fsm_e;
  typedef struct packed {
    wlc_op_e op;
    logic [31:0] arg;
  } wlc_cmd_s;
  typedef struct packed {
    wlc_op_e op;
    wlc_status_e status;
    logic [47:0] data;
  } wlc_rsp_s;
  typedef struct packed {
    wlc_fsm_e fsm;
    logic [2:0] mode;
    logic standby;
    logic hr_meta;
    logic hr_sync;
    logic hr_last;
    logic cts_meta;
    logic cts_sync;
    logic [11:0] gi_meta;
    logic [11:0] gi_sync;
    logic ready;
    logic [2:0] baud;
    logic [1:0] parity;
    logic stop2;
    logic wep;
    logic key128;
    logic auth_closed;
    logic attached;
    logic [31:0] ssid;
    logic adhoc;
    logic [3:0] channel;
    logic [1:0] region;
    logic [1:0] adc_on;
    logic scan;
    logic [11:0] gpio_dir;
    logic [11:0] gpio_out;
    wlc_rsp_s rsp;
    logic wb_ack;
    logic [31:0] wb_dat;
  } wlc_state_s;
endpackage

// ==== hdl/wlc_cmd_top.sv ====
// Command interpreter and power-save controller of the wireless module
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "wlc_regs.svh"

// Overview of operation
// - Serial config takes seven baud rates, even/odd parity, one or two stops.
// - Serial config refused unless character length is eight bits.
// - Security command selects no security or WEP from host flag.
// - Key command takes 10 or 26 hex digits for 64/128-bit key.
// - Authentication command picks open or closed, used with WEP.
// - Search command starts an access point scan and reports results.
// - Attach joins the named SSID; detach leaves the current one.
// - Network type command switches infrastructure or ad-hoc operation.
// - Channel command sets ad-hoc channel, 1-11, 1-13 or 1-14 by region.
// - Low power command selects mode 0, 1, 2 or 5 only.
// - Signal level query returns strength of current access point link.
// - Region query returns configured region; region set changes it.
// - ADC setup enables a channel; ADC sample returns its value.
// - Pin direction commands make selected GPIO lines outputs or inputs.
// - Drive commands set outputs high or low; sense reads input lines.
// - Mode 1: radio in IEEE power save, controller stays fully awake.
// - Mode 2: host-ready falling puts controller into standby.
// - Standby ends on access point packet or host-ready asserted.
// - After start-up the device is in mode 5 with radio off.
// - In mode 5 host sends only serial config, low power, address, version.
// - Other commands refused until mode 1 or mode 0 is entered.
// - Mode 1 is not available in ad-hoc operation.
// - Serial port powers up at 115200 baud, no parity, 8 bits, 1 stop.
// - Flow control out and in are active low RTS/CTS handshakes.
// - Flow control held deasserted after reset until ready for commands.
module wlc_cmd_top #(
  parameter int GPIO_N = 12,
  parameter logic [47:0] HW_ADDR = 48'h02_00_00_00_00_01, // Arbitrary
  parameter logic [31:0] VERSION = 32'h0000_0100 // Arbitrary
) (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic WB_STB_I,
  input wire logic WB_CYC_I,
  output logic WB_ACK_O,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire wlc_pkg::wlc_cmd_s CMD,
  output logic RSP_VALID,
  input wire logic RSP_READY,
  output wlc_pkg::wlc_rsp_s RSP,
  input wire logic HOST_READY,
  input wire logic HOST_CTS_N,
  output logic MOD_RTS_N,
  output logic [2:0] BAUD_CODE,
  output logic [15:0] BAUD_DIV,
  output logic [1:0] PARITY,
  output logic STOP2,
  input wire logic AP_PKT,
  input wire logic [7:0] AP_COUNT,
  input wire logic [7:0] RSSI,
  output logic SCAN_START,
  output logic LINK_ATTACH,
  output logic [31:0] LINK_SSID,
  output logic ADHOC,
  output logic [3:0] CHANNEL,
  output logic WEP_EN,
  output logic KEY_128,
  output logic AUTH_CLOSED,
  output logic RADIO_PS,
  output logic RADIO_OFF,
  output logic CPU_STANDBY,
  output logic [1:0] ADC_EN,
  input wire logic [19:0] ADC_DATA,
  input wire logic [GPIO_N-1:0] GPIO_I,
  output logic [GPIO_N-1:0] GPIO_O,
  output logic [GPIO_N-1:0] GPIO_OE_N
);
  import wlc_pkg::*;

  wlc_state_s r;
  wlc_state_s n;
  logic accept;
  logic ok;
  logic allowed5;
  logic [47:0] data;
  logic [3:0] chmax;
  logic [11:0] mask;
  logic [31:0] a;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);

  // Commands are taken only when idle, software ready and not in standby
  assign CMD_READY = (r.fsm == ST_IDLE) && r.ready && !r.standby;
  assign accept = CMD_VALID && CMD_READY;
  assign a = CMD.arg;
  assign mask = a[11:0];

  // Response leaves only while the host's CTS is asserted
  assign RSP_VALID = (r.fsm == ST_RESP) && !r.cts_sync;
  assign RSP = r.rsp;
  // RTS falls away while busy, in standby or before software says ready
  assign MOD_RTS_N = !(r.ready && r.fsm == ST_IDLE && !r.standby);

  assign BAUD_CODE = r.baud;
  assign PARITY = r.parity;
  assign STOP2 = r.stop2;
  assign SCAN_START = r.scan;
  assign LINK_ATTACH = r.attached;
  assign LINK_SSID = r.ssid;
  assign ADHOC = r.adhoc;
  assign CHANNEL = r.channel;
  assign WEP_EN = r.wep;
  assign KEY_128 = r.key128;
  assign AUTH_CLOSED = r.auth_closed;
  // Radio follows the mode; mode 2 keeps IEEE saving during standby
  assign RADIO_PS = (r.mode == `WLC_MODE_PS1) ||
                    (r.mode == `WLC_MODE_PS2);
  assign RADIO_OFF = (r.mode == `WLC_MODE_PS5);
  assign CPU_STANDBY = r.standby;
  assign ADC_EN = r.adc_on;
  assign GPIO_O = r.gpio_out;
  assign GPIO_OE_N = ~r.gpio_dir;
  assign WB_ACK_O = r.wb_ack;
  assign WB_DAT_O = r.wb_dat;

  // Bit-clock divisor; constant divisions so no divider is built
  always_comb begin
    case (r.baud)
      3'h0: BAUD_DIV = 16'(`WLC_CLK_HZ / `WLC_BAUD_9600);
      3'h1: BAUD_DIV = 16'(`WLC_CLK_HZ / `WLC_BAUD_19200);
      3'h2: BAUD_DIV = 16'(`WLC_CLK_HZ / `WLC_BAUD_38400);
      3'h3: BAUD_DIV = 16'(`WLC_CLK_HZ / `WLC_BAUD_57600);
      3'h4: BAUD_DIV = 16'(`WLC_CLK_HZ / `WLC_BAUD_115200);
      3'h5: BAUD_DIV = 16'(`WLC_CLK_HZ / `WLC_BAUD_230400);
      default: BAUD_DIV = 16'(`WLC_CLK_HZ / `WLC_BAUD_921600);
    endcase
  end

  // Channel ceiling follows the configured region
  always_comb begin
    case (r.region)
      2'h1: chmax = `WLC_CHMAX_US;
      2'h2: chmax = `WLC_CHMAX_JP;
      default: chmax = `WLC_CHMAX_EU;
    endcase
  end

  // Only four commands pass while the radio is powered down
  assign allowed5 = (CMD.op == uart_config_cmd) ||
                    (CMD.op == low_power_cmd) ||
                    (CMD.op == hw_addr_cmd) ||
                    (CMD.op == version_query);

  // Next state: synchronisers, command decode, standby and bus slave
  always_comb begin
    n = r;
    ok = 1'b1;
    data = 48'h0;
    n.scan = 1'b0;
    n.wb_ack = 1'b0;
    // Pins pass two flops; stage one feeds stage two only
    n.hr_meta = HOST_READY;
    n.hr_sync = r.hr_meta;
    n.hr_last = r.hr_sync;
    n.cts_meta = HOST_CTS_N;
    n.cts_sync = r.cts_meta;
    n.gi_meta = GPIO_I;
    n.gi_sync = r.gi_meta;
    if (r.mode == `WLC_MODE_PS5 && !allowed5) begin
      ok = 1'b0;
    end else begin
      case (CMD.op)
        uart_config_cmd: begin
          ok = (a[`WLC_UA_LEN] == `WLC_UA_LEN8) &&
               (a[`WLC_UA_BAUD] <= `WLC_BAUD_MAX) &&
               (a[`WLC_UA_PAR] != `WLC_PAR_BAD);
          if (ok && accept) begin
            n.baud = a[`WLC_UA_BAUD];
            n.parity = a[`WLC_UA_PAR];
            n.stop2 = a[`WLC_UA_STOP];
          end
        end
        security_cmd: if (accept) begin
          n.wep = a[`WLC_FLAG_BIT];
        end
        key_cmd: begin
          ok = (a[`WLC_KEY_DIGITS] == `WLC_KEY64_DIGITS) ||
               (a[`WLC_KEY_DIGITS] == `WLC_KEY128_DIGITS);
          if (ok && accept) begin
            n.key128 = (a[`WLC_KEY_DIGITS] == `WLC_KEY128_DIGITS);
          end
        end
        auth_cmd: if (accept) begin
          n.auth_closed = a[`WLC_FLAG_BIT];
        end
        search_cmd: begin
          n.scan = accept;
          data = {40'h0, AP_COUNT};
        end
        attach_cmd: begin
          ok = (a != 32'h0); // Empty SSID handle has nothing to join
          if (ok && accept) begin
            n.attached = 1'b1;
            n.ssid = a;
          end
        end
        detach_cmd: if (accept) begin
          n.attached = 1'b0;
        end
        network_type_cmd: begin
          // Ad-hoc refused while mode 1 needs infrastructure beacons
          ok = !(a[`WLC_FLAG_BIT] && r.mode == `WLC_MODE_PS1);
          if (ok && accept) begin
            n.adhoc = a[`WLC_FLAG_BIT];
          end
        end
        channel_cmd: begin
          ok = (a[`WLC_CHAN_FLD] != 4'h0) &&
               (a[`WLC_CHAN_FLD] <= chmax);
          if (ok && accept) begin
            n.channel = a[`WLC_CHAN_FLD];
          end
        end
        hw_addr_cmd: data = HW_ADDR;
        low_power_cmd: begin
          ok = (a[`WLC_MODE_FLD] == `WLC_MODE_ON) ||
               (a[`WLC_MODE_FLD] == `WLC_MODE_PS1) ||
               (a[`WLC_MODE_FLD] == `WLC_MODE_PS2) ||
               (a[`WLC_MODE_FLD] == `WLC_MODE_PS5);
          if (a[`WLC_MODE_FLD] == `WLC_MODE_PS1 && r.adhoc) begin
            ok = 1'b0;
          end
          // Leaving mode 5 must go through mode 1 or mode 0
          if (r.mode == `WLC_MODE_PS5 &&
              a[`WLC_MODE_FLD] == `WLC_MODE_PS2) begin
            ok = 1'b0;
          end
          if (ok && accept) begin
            n.mode = a[`WLC_MODE_FLD];
          end
        end
        signal_level_query: begin
          ok = r.attached;
          data = {40'h0, RSSI};
        end
        region_query: data = {46'h0, r.region};
        region_set_cmd: begin
          ok = (a[`WLC_REGION_FLD] != `WLC_REGION_BAD);
          if (ok && accept) begin
            n.region = a[`WLC_REGION_FLD];
          end
        end
        adc_setup_cmd: if (accept) begin
          n.adc_on[a[0]] = 1'b1;
        end
        adc_sample_cmd: begin
          ok = r.adc_on[a[0]];
          data = a[0] ? {38'h0, ADC_DATA[19:10]} : {38'h0, ADC_DATA[9:0]};
        end
        pin_dir_out_cmd: if (accept) begin
          n.gpio_dir = r.gpio_dir | mask;
        end
        pin_dir_in_cmd: if (accept) begin
          n.gpio_dir = r.gpio_dir & ~mask;
        end
        pin_drive_high_cmd: if (accept) begin
          n.gpio_out = r.gpio_out | mask;
        end
        pin_drive_low_cmd: if (accept) begin
          n.gpio_out = r.gpio_out & ~mask;
        end
        pin_sense_cmd: data = {36'h0, r.gi_sync & ~r.gpio_dir & mask};
        version_query: data = {16'h0, VERSION};
        default: ok = 1'b0;
      endcase
    end
    // Handshake: one response frame per taken command
    case (r.fsm)
      ST_IDLE: if (accept) begin
        n.rsp.op = CMD.op;
        n.rsp.status = ok ? RSP_OK : RSP_REJECT;
        n.rsp.data = ok ? data : 48'h0;
        n.fsm = ST_RESP;
      end
      ST_RESP: if (RSP_READY && !r.cts_sync) begin
        n.fsm = ST_IDLE;
      end
      default: n.fsm = ST_IDLE;
    endcase
    // Standby: leaving wins over a fresh falling edge of host-ready
    if (r.standby) begin
      if (AP_PKT || r.hr_sync || r.mode != `WLC_MODE_PS2) begin
        n.standby = 1'b0;
      end
    end else if (r.mode == `WLC_MODE_PS2 && r.hr_last && !r.hr_sync) begin
      n.standby = 1'b1;
    end
    // Bus slave answers one cycle after the request, dropped next cycle
    // A write lands at the edge where the master samples ack, not before
    if (WB_CYC_I && WB_STB_I && r.wb_ack && WB_WE_I && WB_SEL_I[0] &&
        WB_ADR_I == `WLC_CTRL_OFS) begin
      n.ready = WB_DAT_I[`WLC_CTRL_READY_BIT];
    end
    if (WB_CYC_I && WB_STB_I && !r.wb_ack) begin
      n.wb_ack = 1'b1;
      n.wb_dat = 32'h0;
      if (WB_ADR_I == `WLC_CTRL_OFS) begin
        n.wb_dat = {31'h0, r.ready};
      end else if (WB_ADR_I == `WLC_STATUS_OFS) begin
        n.wb_dat = {16'h0, r.adc_on, r.hr_sync, r.attached, r.auth_closed,
                    r.key128, r.wep, r.adhoc, r.fsm == ST_RESP, r.standby,
                    r.ready, r.mode, 1'b0, r.cts_sync};
      end else if (WB_ADR_I == `WLC_LINK_OFS) begin
        n.wb_dat = {18'h0, r.region, r.channel, 1'b0, r.stop2, r.parity,
                    1'b0, r.baud};
      end else if (WB_ADR_I == `WLC_GPIO_OFS) begin
        n.wb_dat = {8'h0, r.gi_sync, r.gpio_dir};
      end
    end
  end

  // State register with synchronous reset to power-up defaults
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      r <= '0;
      r.fsm <= ST_IDLE;
      r.mode <= `WLC_MODE_RST;
      r.baud <= `WLC_BAUD_RST;
      r.parity <= `WLC_PAR_NONE;
      r.channel <= `WLC_CHAN_RST;
      r.region <= `WLC_REGION_RST;
      r.cts_meta <= 1'b1;
      r.cts_sync <= 1'b1;
    end else begin
      r <= n;
    end
  end

  power_on_mode_a:
    assert property ($past(!RST_B) |-> RADIO_OFF && r.mode == 3'h5)
    else $error("Not in mode 5 after reset");
  serial_default_a:
    assert property ($past(!RST_B) |-> BAUD_DIV == 16'd1085 &&
                     PARITY == 2'h0 && !STOP2)
    else $error("Serial default not 115200 n 8 1");
  rts_hold_a:
    assert property (!r.ready |-> MOD_RTS_N)
    else $error("RTS asserted before ready");
  mode5_gate_a:
    assert property (accept && r.mode == 3'h5 && !allowed5 |=>
                     RSP.status == RSP_REJECT && r.mode == 3'h5)
    else $error("Command accepted in mode 5");
  word_len_a:
    assert property (accept && CMD.op == uart_config_cmd &&
                     CMD.arg[15:12] != 4'h8 |=>
                     RSP.status == RSP_REJECT && $stable(BAUD_CODE))
    else $error("Non 8-bit length accepted");
  resp_every_a:
    assert property (accept |=> r.fsm == ST_RESP && RSP.op == $past(CMD.op))
    else $error("No response after command");
  standby_enter_a:
    assert property (!r.standby && r.mode == 3'h2 && $fell(r.hr_sync) |=>
                     CPU_STANDBY && RADIO_PS)
    else $error("Standby not entered in mode 2");
  standby_exit_a:
    assert property (r.standby && (AP_PKT || r.hr_sync) |=> !CPU_STANDBY)
    else $error("Standby not left on wake event");
  ps1_adhoc_a:
    assert property (ADHOC |-> r.mode != 3'h1)
    else $error("Mode 1 with ad-hoc");
  ps1_awake_a:
    assert property (r.mode == 3'h1 |-> RADIO_PS && !CPU_STANDBY)
    else $error("Mode 1 not awake with IEEE saving");
  channel_range_a:
    assert property (accept && r.mode != 3'h5 && CMD.op == channel_cmd &&
                     CMD.arg[3:0] > chmax |=> RSP.status == RSP_REJECT)
    else $error("Channel beyond region accepted");
endmodule
`default_nettype wire

// ==== verif/wlc_host_model.sv ====
// Host side of the command port: receive flow control and response intake
`timescale 1ns/10ps
`default_nettype none
module wlc_host_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic hold,
  input wire logic rts_n,
  output logic cts_n,
  output logic rsp_ready
);
  logic seen_rts;

  // Host stays closed until the module first shows it is ready
  always @(posedge clk) begin
    if (!rst_b) begin
      seen_rts <= 1'b0;
      cts_n <= 1'b1;
      rsp_ready <= 1'b0;
    end else begin
      seen_rts <= seen_rts | ~rts_n;
      // Active low; a slow host drops it at random to stall responses
      cts_n <= hold | ~seen_rts | (slow & ($urandom % 4 == 0));
      rsp_ready <= ~slow | ($urandom % 2 == 0);
    end
  end
endmodule
`default_nettype wire

// ==== verif/test_wlan_module_command_powersave.sv ====
// Self-checking bench for the command interpreter and power-save control
`timescale 1ns/10ps
`default_nettype none
`include "wlc_regs.svh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin errors++; \
  $display("mismatch %s exp %0h got %0h", n, e, a); end end
module test_wlan_module_command_powersave;
  import wlc_pkg::*;
  localparam wlc_status_e ok = RSP_OK;
  localparam wlc_status_e rj = RSP_REJECT;
  logic clk, rst_b, wb_we, wb_stb, wb_cyc, wb_ack, cmd_v, cmd_r, rsp_v;
  logic rsp_r, host_rdy, cts_n, rts_n, stop2, ap_pkt, scan, attach, adhoc;
  logic wep, k128, auth, r_ps, r_off, sby, slow, hold;
  logic [3:0] wb_adr, chan;
  logic [31:0] wb_di, wb_do, ssid, rd, sid;
  logic [2:0] baud;
  logic [15:0] div;
  logic [1:0] par, adc_en;
  logic [7:0] ap_cnt, rssi;
  logic [19:0] adc;
  logic [11:0] gi, go, goe_n, m;
  wlc_cmd_s cmd_d;
  wlc_rsp_s rsp;
  logic [55:0] exp_q[$];
  int errors, checks, scans;
  int rates[7] = '{9600, 19200, 38400, 57600, 115200, 230400, 921600};

  wlc_cmd_top i_dut (
    .REF_CLK(clk), .RST_B(rst_b), .WB_ADR_I(wb_adr), .WB_DAT_I(wb_di),
    .WB_DAT_O(wb_do), .WB_WE_I(wb_we), .WB_SEL_I(4'hF),
    .WB_STB_I(wb_stb), .WB_CYC_I(wb_cyc), .WB_ACK_O(wb_ack),
    .CMD_VALID(cmd_v), .CMD_READY(cmd_r), .CMD(cmd_d), .RSP_VALID(rsp_v),
    .RSP_READY(rsp_r), .RSP(rsp), .HOST_READY(host_rdy),
    .HOST_CTS_N(cts_n), .MOD_RTS_N(rts_n), .BAUD_CODE(baud),
    .BAUD_DIV(div), .PARITY(par), .STOP2(stop2), .AP_PKT(ap_pkt),
    .AP_COUNT(ap_cnt), .RSSI(rssi), .SCAN_START(scan),
    .LINK_ATTACH(attach), .LINK_SSID(ssid), .ADHOC(adhoc), .CHANNEL(chan),
    .WEP_EN(wep), .KEY_128(k128), .AUTH_CLOSED(auth), .RADIO_PS(r_ps),
    .RADIO_OFF(r_off), .CPU_STANDBY(sby), .ADC_EN(adc_en),
    .ADC_DATA(adc), .GPIO_I(gi), .GPIO_O(go), .GPIO_OE_N(goe_n));

  wlc_host_model i_host (.clk(clk), .rst_b(rst_b), .slow(slow),
    .hold(hold), .rts_n(rts_n), .cts_n(cts_n), .rsp_ready(rsp_r));

  // Free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Oldest noted expectation against each response the host takes
  always @(posedge clk) begin
    if (scan === 1'b1) scans++;
    if (rsp_v === 1'b1 && rsp_r === 1'b1) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("mismatch rsp_count exp 0 got 1");
      end else begin
        `CHK("rsp", exp_q[0][6:0], {rsp.op, rsp.status})
        if (exp_q[0][1:0] === rj)
          `CHK("rej_data", 48'h0, rsp.data)
        else if (exp_q[0][55])
          `CHK("rsp_data", exp_q[0][54:7], rsp.data)
        void'(exp_q.pop_front());
      end
    end
  end

  task automatic stop_test();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // An exhausted bus or command wait ends the run as a failure
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      errors++;
      $display("mismatch timeout exp %0d got %0d", lim, n);
      stop_test();
    end
  endtask

  // Classic single Wishbone cycle, held until ack is sampled
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_adr <= a;
    wb_we <= w;
    wb_di <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    tmo(n, 50);
    rd = wb_do;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask

  // One command; returns once its response has been taken
  task automatic cmd(input wlc_op_e op, input logic [31:0] arg,
                     input wlc_status_e st, input logic [48:0] d = 49'h0);
    int n;
    n = 0;
    exp_q.push_back({d, op, st});
    cmd_v <= 1'b1;
    cmd_d <= {op, arg};
    do begin
      @(posedge clk);
      n++;
    end while (cmd_r !== 1'b1 && n < 200);
    cmd_v <= 1'b0;
    while (exp_q.size() != 0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    tmo(n, 400);
    @(posedge clk);
  endtask

  // Standby change must lag the pin by the synchroniser, but not by much
  task automatic wsb(input logic v, input int lo);
    int n;
    n = 0;
    while (sby !== v && n < 12) begin
      @(posedge clk);
      n++;
    end
    `CHK("standby", v, sby)
    `CHK("sync_lag", 1'b1, n >= lo)
  endtask

  // Main sequence
  initial begin
    int n, p, s;
    void'($urandom(32'hb92a5813));
    {wb_we, wb_stb, wb_cyc, cmd_v, ap_pkt, slow, hold} = '0;
    {rst_b, wb_adr, wb_di, cmd_d, host_rdy} = '0;
    host_rdy = 1'b1;
    {ap_cnt, rssi, adc, gi} = 48'({$urandom, $urandom});
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    `CHK("rts_rst", 1'b1, rts_n)
    `CHK("radio_off", 1'b1, r_off)
    `CHK("div_rst", `WLC_CLK_HZ / 115200, div)
    `CHK("link_rst", 6'h20, {baud, par, stop2})
    wb(4'h8, 1'b0, 32'h0);
    `CHK("link_reg", 14'h0104, rd[13:0])
    wb(4'h2, 1'b0, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    `CHK("rts_idle", 1'b1, rts_n)
    wb(4'h0, 1'b1, 32'h1);
    wb(4'h4, 1'b0, 32'h0);
    `CHK("status", 4'hD, rd[5:2])
    for (n = 0; n < 20 && rts_n !== 1'b0; n++) @(posedge clk);
    `CHK("rts_ready", 1'b0, rts_n)
    // Mode 5 gating: only the four permitted commands pass
    cmd(search_cmd, 32'h0, rj);
    cmd(channel_cmd, 32'h3, rj);
    cmd(version_query, 32'h0, ok);
    cmd(hw_addr_cmd, 32'h0, ok);
    for (int i = 0; i < 7; i++) begin
      p = $urandom_range(2, 1);
      s = $urandom_range(1, 0);
      cmd(uart_config_cmd, 32'h8000 | (s << 8) | (p << 4) | i, ok);
      `CHK("baud", 3'(i), baud)
      `CHK("div", `WLC_CLK_HZ / rates[i], div)
      `CHK("par", p, par)
      `CHK("stop", s, stop2)
    end
    cmd(uart_config_cmd, 32'h7004, rj);
    cmd(uart_config_cmd, 32'h8034, rj);
    cmd(uart_config_cmd, 32'h8007, rj);
    `CHK("baud_kept", 3'h6, baud)
    cmd(low_power_cmd, 32'h3, rj);
    cmd(low_power_cmd, 32'h2, rj);
    cmd(low_power_cmd, 32'h1, ok);
    `CHK("ps1", 2'h2, {r_ps, r_off})
    cmd(network_type_cmd, 32'h1, rj);
    cmd(low_power_cmd, 32'h0, ok);
    cmd(network_type_cmd, 32'h1, ok);
    `CHK("adhoc", 1'b1, adhoc)
    cmd(low_power_cmd, 32'h1, rj);
    cmd(channel_cmd, 32'h0, rj);
    cmd(channel_cmd, 32'hC, rj);
    cmd(channel_cmd, 32'hB, ok);
    `CHK("chan", 4'hB, chan)
    cmd(region_set_cmd, 32'h3, rj);
    cmd(region_set_cmd, 32'h2, ok);
    cmd(channel_cmd, 32'hE, ok);
    `CHK("chan_jp", 4'hE, chan)
    cmd(security_cmd, 32'h1, ok);
    cmd(auth_cmd, 32'h1, ok);
    cmd(key_cmd, 32'h0B, rj);
    cmd(key_cmd, 32'h1A, ok);
    `CHK("key128", 3'h7, {wep, k128, auth})
    cmd(key_cmd, 32'h0A, ok);
    `CHK("key64", 1'b0, k128)
    sid = $urandom | 32'h1;
    cmd(attach_cmd, 32'h0, rj);
    cmd(attach_cmd, sid, ok);
    `CHK("ssid", {1'b1, sid}, {attach, ssid})
    cmd(signal_level_query, 32'h0, ok, {1'b1, 40'h0, rssi});
    cmd(detach_cmd, 32'h0, ok);
    `CHK("detach", 1'b0, attach)
    cmd(signal_level_query, 32'h0, rj);
    cmd(search_cmd, 32'h0, ok, {1'b1, 40'h0, ap_cnt});
    `CHK("scan", 1, scans)
    cmd(adc_sample_cmd, 32'h1, rj);
    cmd(adc_setup_cmd, 32'h1, ok);
    `CHK("adc_en", 2'h2, adc_en)
    cmd(adc_sample_cmd, 32'h1, ok, {1'b1, 38'h0, adc[19:10]});
    m = 12'($urandom);
    cmd(pin_dir_out_cmd, m, ok);
    `CHK("oe_n", ~m, goe_n)
    cmd(pin_drive_high_cmd, 32'hFFF, ok);
    cmd(pin_drive_low_cmd, m, ok);
    `CHK("gpio_o", ~m, go)
    cmd(pin_sense_cmd, ~m, ok, {1'b1, 36'h0, gi & ~m});
    wb(4'hC, 1'b0, 32'h0);
    `CHK("gpio_reg", {gi, m}, rd[23:0])
    // A closed host holds the response back and the module stays busy
    hold <= 1'b1;
    // Closed CTS must clear the synchroniser before the command goes in
    repeat (4) @(posedge clk);
    fork
      cmd(region_query, 32'h0, ok, {1'b1, 46'h0, 2'h2});
      begin
        repeat (12) @(posedge clk);
        `CHK("rsp_gated", 1'b0, rsp_v)
        `CHK("rts_busy", 1'b1, rts_n)
        hold <= 1'b0;
      end
    join
    // Host-driven standby in mode 2, woken by a packet and by the host
    cmd(network_type_cmd, 32'h0, ok);
    cmd(low_power_cmd, 32'h2, ok);
    host_rdy <= 1'b0;
    wsb(1'b1, 3);
    `CHK("cmd_sby", 1'b0, cmd_r)
    ap_pkt <= 1'b1;
    @(posedge clk);
    ap_pkt <= 1'b0;
    wsb(1'b0, 0);
    host_rdy <= 1'b1;
    repeat (6) @(posedge clk);
    host_rdy <= 1'b0;
    wsb(1'b1, 3);
    host_rdy <= 1'b1;
    wsb(1'b0, 3);
    // Slow host stalls at random between responses
    slow <= 1'b1;
    for (int i = 0; i < 6; i++) cmd(version_query, 32'h0, ok);
    stop_test();
  end
endmodule
`default_nettype wire
